/* core/mpu_map.vh */
// Register offsets, field positions and encodings of the region protection unit.
`ifndef MPU_MAP_VH
`define MPU_MAP_VH
`define OFS_CTRL 5'h00
`define OFS_COUNT 5'h04
`define OFS_SELECT 5'h08
`define OFS_BASE 5'h0c
`define OFS_ATTR 5'h10
`define OFS_REGION_ON 5'h14
`define OFS_FAULT_ADDR 5'h18
`define CTRL_ENABLE 0
`define CTRL_PRIV_DEFAULT 1
`define CTRL_PROTECT_HANDLERS 2
`define CTRL_FAULT_IRQ_EN 3
`define BASE_LSB 5
`define ATTR_ON 0
`define ATTR_SIZE_LSB 1
`define ATTR_SIZE_W 5
`define ATTR_SUBOFF_LSB 8
`define ATTR_PERM_LSB 24
`define ATTR_XN 28
`define COUNT_LSB 8
`define SIZE_SMALLEST 5'h04
`define SIZE_SUBREGION_MIN 5'h07
`define SIZE_SUB_SHIFT 5'h02
`define PERM_NONE_NONE 3'h0
`define PERM_PRIV_RW_USER_NONE 3'h1
`define PERM_PRIV_RW_USER_RO 3'h2
`define PERM_PRIV_RW_USER_RW 3'h3
`define PERM_PRIV_RO_USER_NONE 3'h5
`define PERM_PRIV_RO_USER_RO 3'h6
`endif

/* core/region_memory_protection.v */
// Region based memory protection unit checking core accesses against eight regions.
//
// Operation
// - Globally disabled: default map for every access, never a fault.
// - Eight regions, index 0 to 7, each with base, attributes, enable.
// - Clearing a region enable keeps its base and attributes.
// - Globally enabled: permission violation of the applicable region faults.
// - Privileged default option: privileged miss uses default map.
// - Handler option set checks in fault handlers; clear bypasses to default.
// - No options: no privileged default, no checks inside fault handlers.
// - Region rules apply only while its enable bit is set.
// - A readable value gives the total number of regions.
// - Size field encodes 32 bytes to 4 gigabytes and sets the range.
// - Execute-never bit set makes instruction fetches from the region fault.
// - Privileged and user read/write permissions enforced per six combinations.
// - Eight equal sub-regions, each with a disable bit that unmatches it.
// - Sub-region disables act only for regions of 256 bytes or more.
// - A disabled sub-region leaves the address for other regions.
// - The attribute write carries the region enable bit.
// - Base and attributes of the selected region read back.
// - The fault is an interrupt source with its own enable.
// - Enabled, no privileged default, no enabled region: every access faults; handler accesses still use the default map while the handler option is clear.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`include "mpu_map.vh"

module region_memory_protection #(
  parameter NUM_REGIONS = 8,
  parameter IDX_W = 3
) (
  input wire clock_i, // Core clock.
  input wire srst_i, // Synchronous reset, active high.
  input wire [4:0] reg_addr_i, // Register byte address.
  input wire [31:0] reg_wdata_i, // Register write data.
  input wire reg_wr_i, // Register write strobe.
  input wire reg_rd_i, // Register read strobe.
  output reg [31:0] reg_rdata_o, // Read data, cycle after the read strobe.
  input wire acc_valid_i, // Core access to check.
  input wire [31:0] acc_addr_i, // Access address.
  input wire acc_write_i, // Access is a write.
  input wire acc_fetch_i, // Access is an instruction fetch.
  input wire acc_priv_i, // Access is privileged.
  input wire acc_in_handler_i, // Core runs a hard fault or NMI handler.
  output reg acc_done_o, // Check result valid, one cycle after the access.
  output reg acc_fault_o, // Memory management fault for the access.
  output reg acc_default_map_o, // Access resolved by the default memory map.
  output reg [IDX_W-1:0] acc_region_o, // Region that decided the access.
  output reg fault_irq_o // Fault interrupt request, gated by its enable.
);

  localparam [31:0] REGION_COUNT = NUM_REGIONS;

  // Global options and the region pointer.

  reg mpu_on_q;
  reg privileged_default_map_option_q;
  reg protect_in_fault_handlers_option_q;
  reg fault_irq_en_q;
  reg [IDX_W-1:0] select_q;
  reg [31:0] fault_addr_q;

  // Per-region storage; an array holds each field for all regions.
  reg [NUM_REGIONS-1:0] region_on_q;
  reg [31-`BASE_LSB:0] base_q [0:NUM_REGIONS-1];
  reg [`ATTR_SIZE_W-1:0] size_q [0:NUM_REGIONS-1];
  reg [7:0] sub_off_q [0:NUM_REGIONS-1];
  reg [2:0] perm_q [0:NUM_REGIONS-1];
  reg xn_q [0:NUM_REGIONS-1];
  wire [NUM_REGIONS-1:0] hit;


  // One write strobe per register; unmapped and read-only addresses decode to nothing.
  reg wr_ctrl;
  reg wr_sel;
  reg wr_base;
  reg wr_attr;
  reg wr_on;
  always @* begin
    wr_ctrl = 1'b0;
    wr_sel = 1'b0;
    wr_base = 1'b0;
    wr_attr = 1'b0;
    wr_on = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `OFS_CTRL: begin
          wr_ctrl = 1'b1;
        end
        `OFS_SELECT: begin
          wr_sel = 1'b1;
        end
        `OFS_BASE: begin
          wr_base = 1'b1;
        end
        `OFS_ATTR: begin
          wr_attr = 1'b1;
        end
        `OFS_REGION_ON: begin
          wr_on = 1'b1;
        end
        default: begin
          wr_ctrl = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      mpu_on_q <= 1'b0;
      privileged_default_map_option_q <= 1'b0;
      protect_in_fault_handlers_option_q <= 1'b0;
      fault_irq_en_q <= 1'b0;
      select_q <= {IDX_W{1'b0}};
    end else begin
      if (wr_ctrl) begin
        mpu_on_q <= reg_wdata_i[`CTRL_ENABLE];
        privileged_default_map_option_q <= reg_wdata_i[`CTRL_PRIV_DEFAULT];
        protect_in_fault_handlers_option_q <= reg_wdata_i[`CTRL_PROTECT_HANDLERS];
        fault_irq_en_q <= reg_wdata_i[`CTRL_FAULT_IRQ_EN];
      end
      if (wr_sel) begin
        select_q <= reg_wdata_i[IDX_W-1:0];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g = g + 1) begin : region
      wire [`ATTR_SIZE_W-1:0] n;
      wire [5:0] np1;
      wire [31:0] low_mask;
      wire [`ATTR_SIZE_W-1:0] sh;
      wire [31:0] shifted;
      wire in_range;
      wire sub_blocked;
      wire [31:0] base_addr;
      localparam [IDX_W-1:0] IDX = g;
      wire sel = (select_q == IDX);

      // Codes below the smallest size behave as the smallest size.
      assign n = (size_q[g] < `SIZE_SMALLEST) ? `SIZE_SMALLEST : size_q[g];
      assign np1 = {1'b0, n} + 6'h01;
      assign low_mask = (32'h1 << np1) - 32'h1;
      assign base_addr = {base_q[g], {`BASE_LSB{1'b0}}};
      // Base bits below the region size are masked off, so a misaligned base still matches.
      assign in_range = (((acc_addr_i ^ base_addr) & ~low_mask) == 32'h0);

      // Each sub-region is one eighth of the region; three address bits above it pick it.
      assign sh = n - `SIZE_SUB_SHIFT;
      assign shifted = acc_addr_i >> sh;
      assign sub_blocked = (n >= `SIZE_SUBREGION_MIN) && sub_off_q[g][shifted[2:0]];
      assign hit[g] = region_on_q[g] && in_range && !sub_blocked;

      always @(posedge clock_i) begin
        if (srst_i) begin
          region_on_q[g] <= 1'b0;
          base_q[g] <= {(32-`BASE_LSB){1'b0}};
          size_q[g] <= `SIZE_SMALLEST;
          sub_off_q[g] <= 8'h00;
          perm_q[g] <= `PERM_NONE_NONE;
          xn_q[g] <= 1'b0;
        end else begin
          if (wr_base && sel) begin
            base_q[g] <= reg_wdata_i[31:`BASE_LSB];
          end
          if (wr_attr && sel) begin
            size_q[g] <= reg_wdata_i[`ATTR_SIZE_LSB +: `ATTR_SIZE_W];
            sub_off_q[g] <= reg_wdata_i[`ATTR_SUBOFF_LSB +: 8];
            perm_q[g] <= reg_wdata_i[`ATTR_PERM_LSB +: 3];
            xn_q[g] <= reg_wdata_i[`ATTR_XN];
            region_on_q[g] <= reg_wdata_i[`ATTR_ON];
          end else if (wr_on) begin
            // Only the enable changes; base and attributes are kept.
            region_on_q[g] <= reg_wdata_i[g];
          end
        end
      end
    end
  endgenerate

  // Later regions overwrite earlier ones, so the highest numbered hit wins.
  reg any_hit;
  reg [IDX_W-1:0] win;
  integer i;
  always @* begin
    any_hit = 1'b0;
    win = {IDX_W{1'b0}};
    for (i = 0; i < NUM_REGIONS; i = i + 1) begin
      if (hit[i]) begin
        any_hit = 1'b1;
        win = i[IDX_W-1:0];
      end
    end
  end

  // Permission table; unused codes grant nothing to anyone.
  function perm_allows;
    input [2:0] perm;
    input priv;
    input write;
    reg priv_rd;
    reg priv_wr;
    reg user_rd;
    reg user_wr;
    begin
      priv_rd = 1'b0;
      priv_wr = 1'b0;
      user_rd = 1'b0;
      user_wr = 1'b0;
      case (perm)
        `PERM_PRIV_RW_USER_NONE: begin
          priv_rd = 1'b1;
          priv_wr = 1'b1;
        end
        `PERM_PRIV_RW_USER_RO: begin
          priv_rd = 1'b1;
          priv_wr = 1'b1;
          user_rd = 1'b1;
        end
        `PERM_PRIV_RW_USER_RW: begin
          priv_rd = 1'b1;
          priv_wr = 1'b1;
          user_rd = 1'b1;
          user_wr = 1'b1;
        end
        `PERM_PRIV_RO_USER_NONE: begin
          priv_rd = 1'b1;
        end
        `PERM_PRIV_RO_USER_RO: begin
          priv_rd = 1'b1;
          user_rd = 1'b1;
        end
        default: begin
          priv_rd = 1'b0;
        end
      endcase
      if (priv) begin
        perm_allows = write ? priv_wr : priv_rd;
      end else begin
        perm_allows = write ? user_wr : user_rd;
      end
    end
  endfunction

  wire [NUM_REGIONS-1:0] allowed;
  wire [NUM_REGIONS-1:0] exec_blocked;
  generate
    for (g = 0; g < NUM_REGIONS; g = g + 1) begin : region_perm
      assign allowed[g] = perm_allows(perm_q[g], acc_priv_i, acc_write_i);
      assign exec_blocked[g] = acc_fetch_i && xn_q[g];
    end
  endgenerate

  reg region_fault;
  always @* begin
    region_fault = 1'b0;
    if (exec_blocked[win]) begin
      region_fault = 1'b1;
    end else if (!allowed[win]) begin
      region_fault = 1'b1;
    end
  end

  // The handler option decides whether protection stays on inside fault handlers.
  wire handler_bypass = acc_in_handler_i && !protect_in_fault_handlers_option_q;

  reg bypass;
  reg use_default;
  reg fault;
  always @* begin
    bypass = !mpu_on_q;
    if (handler_bypass) begin
      bypass = 1'b1;
    end
    use_default = 1'b0;
    fault = 1'b0;
    if (bypass) begin
      use_default = 1'b1;
    end else if (any_hit) begin
      fault = region_fault;
    end else if (acc_priv_i && privileged_default_map_option_q) begin
      use_default = 1'b1;
    end else begin
      fault = 1'b1;
    end
  end

  // Results stand for exactly one cycle after the access.
  reg acc_done_d;
  reg acc_fault_d;
  reg acc_default_map_d;
  reg fault_irq_d;
  always @* begin
    acc_done_d = acc_valid_i;
    acc_fault_d = acc_valid_i && fault;
    acc_default_map_d = acc_valid_i && use_default;
    fault_irq_d = acc_valid_i && fault && fault_irq_en_q;
  end


  always @(posedge clock_i) begin
    if (srst_i) begin
      acc_done_o <= 1'b0;
      acc_fault_o <= 1'b0;
      acc_default_map_o <= 1'b0;
      acc_region_o <= {IDX_W{1'b0}};
      fault_irq_o <= 1'b0;
      fault_addr_q <= 32'h0;
    end else begin
      acc_done_o <= acc_done_d;
      acc_fault_o <= acc_fault_d;
      acc_default_map_o <= acc_default_map_d;
      acc_region_o <= win;
      fault_irq_o <= fault_irq_d;
      // The last faulting address is kept for the handler to read.
      if (acc_valid_i && fault) begin
        fault_addr_q <= acc_addr_i;
      end
    end
  end

  // Read data are zero except in the cycle after a read strobe.
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0;
    case (reg_addr_i)
      `OFS_CTRL: begin
        rdata_d[`CTRL_ENABLE] = mpu_on_q;
        rdata_d[`CTRL_PRIV_DEFAULT] = privileged_default_map_option_q;
        rdata_d[`CTRL_PROTECT_HANDLERS] = protect_in_fault_handlers_option_q;
        rdata_d[`CTRL_FAULT_IRQ_EN] = fault_irq_en_q;
      end
      `OFS_COUNT: begin
        // The region count is a constant of the build.
        rdata_d[`COUNT_LSB +: 8] = REGION_COUNT[7:0];
      end
      `OFS_SELECT: begin
        rdata_d[IDX_W-1:0] = select_q;
      end
      `OFS_BASE: begin
        rdata_d[31:`BASE_LSB] = base_q[select_q];
      end
      `OFS_ATTR: begin
        rdata_d[`ATTR_ON] = region_on_q[select_q];
        rdata_d[`ATTR_SIZE_LSB +: `ATTR_SIZE_W] = size_q[select_q];
        rdata_d[`ATTR_SUBOFF_LSB +: 8] = sub_off_q[select_q];
        rdata_d[`ATTR_PERM_LSB +: 3] = perm_q[select_q];
        rdata_d[`ATTR_XN] = xn_q[select_q];
      end
      `OFS_REGION_ON: begin
        rdata_d[NUM_REGIONS-1:0] = region_on_q;
      end
      `OFS_FAULT_ADDR: begin
        rdata_d = fault_addr_q;
      end
      default: begin
        // Unused register addresses read as zero.
        rdata_d = 32'h0;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o <= 32'h0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 32'h0;
    end
  end

endmodule

/* testbench/region_memory_protection_monitor.sv */
// Port checker for the region protection unit.
`timescale 1ns/100ps
`include "mpu_map.vh"
module region_memory_protection_monitor #(
  parameter NUM_REGIONS = 8,
  parameter IDX_W = 3
) (
  input wire clock_i, // Clock.
  input wire srst_i, // Reset.
  input wire [4:0] reg_addr_i, // Address.
  input wire [31:0] reg_wdata_i, // Write data.
  input wire reg_wr_i, // Write.
  input wire reg_rd_i, // Read.
  input wire [31:0] reg_rdata_o, // Read data.
  input wire acc_valid_i, // Access.
  input wire [31:0] acc_addr_i, // Address.
  input wire acc_write_i, // Write.
  input wire acc_fetch_i, // Fetch.
  input wire acc_priv_i, // Privileged.
  input wire acc_in_handler_i, // Handler.
  input wire acc_done_o, // Done.
  input wire acc_fault_o, // Fault.
  input wire acc_default_map_o, // Default map.
  input wire [IDX_W-1:0] acc_region_o, // Region.
  input wire fault_irq_o // Interrupt.
);
  logic [3:0] ctrl_q;
  always @(posedge clock_i) begin
    if (srst_i)
      ctrl_q <= 4'h0;
    else if (reg_wr_i && reg_addr_i == `OFS_CTRL)
      ctrl_q <= reg_wdata_i[3:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  a_done_follows: assert property (acc_valid_i |=> acc_done_o)
    else $error("no done after access");
  a_no_stray_done: assert property (!acc_valid_i |=> !acc_done_o)
    else $error("done without access");
  a_off_no_fault: assert property (acc_valid_i && !ctrl_q[0] |=> acc_default_map_o && !acc_fault_o)
    else $error("fault while unit off");
  a_handler_bypass: assert property (acc_valid_i && acc_in_handler_i && !ctrl_q[2]
    |=> acc_default_map_o && !acc_fault_o)
    else $error("handler not bypassed");
  a_result_excl: assert property ((acc_fault_o || acc_default_map_o)
    |-> acc_done_o && !(acc_fault_o && acc_default_map_o))
    else $error("bad result flags");
  a_irq_gated: assert property (acc_done_o |-> fault_irq_o == (acc_fault_o && $past(ctrl_q[3])))
    else $error("interrupt not gated");
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("stray read data");
  a_count_value: assert property (reg_rd_i && reg_addr_i == `OFS_COUNT |=> reg_rdata_o[15:8] == 8'h08)
    else $error("bad region count");
  c_fault_irq: cover property (acc_fault_o && fault_irq_o);
  c_default: cover property (acc_done_o && acc_default_map_o);
  c_match: cover property (acc_done_o && !acc_fault_o && !acc_default_map_o);
endmodule
bind region_memory_protection region_memory_protection_monitor #(.NUM_REGIONS(NUM_REGIONS),
  .IDX_W(IDX_W)) u_mon (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_write_i(acc_write_i),
  .acc_fetch_i(acc_fetch_i), .acc_priv_i(acc_priv_i), .acc_in_handler_i(acc_in_handler_i),
  .acc_done_o(acc_done_o), .acc_fault_o(acc_fault_o), .acc_default_map_o(acc_default_map_o),
  .acc_region_o(acc_region_o), .fault_irq_o(fault_irq_o));

/* testbench/core_access_model.sv */
// Core model that issues accesses and collects their check results.
`timescale 1ns/100ps
module core_access_model (
  input wire logic clock_i, // Clock.
  output logic acc_valid_o, // Access.
  output logic [31:0] acc_addr_o, // Address.
  output logic [3:0] acc_kind_o, // Write, fetch, privileged, handler.
  input wire logic acc_done_i, // Done.
  input wire logic acc_fault_i, // Fault.
  input wire logic acc_default_map_i, // Default map.
  input wire logic [2:0] acc_region_i // Region.
);
  initial begin
    acc_valid_o = 1'b0;
    acc_addr_o = 32'h0;
    acc_kind_o = 4'h0;
  end
  task automatic access(input logic [31:0] a, input logic [3:0] k, output logic [5:0] r);
    @(posedge clock_i);
    acc_valid_o <= 1'b1;
    acc_addr_o <= a;
    acc_kind_o <= k;
    @(posedge clock_i);
    acc_valid_o <= 1'b0;
    // An idle bus must not show the last address.
    acc_addr_o <= ~a;
    acc_kind_o <= ~k;
    #1 r = {acc_done_i, acc_fault_i, acc_default_map_i, acc_region_i};
  endtask
endmodule

/* testbench/region_memory_protection_bench.sv */
// Self-checking bench for the region protection unit.
`timescale 1ns/100ps
`include "mpu_map.vh"
module region_memory_protection_bench;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic [4:0] addr = 5'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic valid, done, fault, dflt, irq;
  logic [31:0] a_addr;
  logic [3:0] kind;
  logic [2:0] region;
  localparam logic [31:0] ok_tab = 32'h0540fdc0;
  int n_mismatch = 0;
  int checks = 0;
  always #4 clock_i = ~clock_i;
  region_memory_protection dut (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
    .acc_valid_i(valid), .acc_addr_i(a_addr), .acc_write_i(kind[3]), .acc_fetch_i(kind[2]),
    .acc_priv_i(kind[1]), .acc_in_handler_i(kind[0]), .acc_done_o(done), .acc_fault_o(fault),
    .acc_default_map_o(dflt), .acc_region_o(region), .fault_irq_o(irq));
  core_access_model u_core (.clock_i(clock_i), .acc_valid_o(valid), .acc_addr_o(a_addr),
    .acc_kind_o(kind), .acc_done_i(done), .acc_fault_i(fault), .acc_default_map_i(dflt),
    .acc_region_i(region));
  task automatic finish_test;
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    @(posedge clock_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Region index is only compared for accesses expected to neither fault nor use the default map.
  task automatic ac(input logic [31:0] a, input logic [3:0] k, input logic [5:0] e);
    logic [5:0] r;
    u_core.access(a, k, r);
    if (e[4:3] != 2'b0)
      r[2:0] = 3'h0;
    chk({26'h0, r}, {26'h0, e});
  endtask
  initial begin
    #40000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(`OFS_COUNT, 32'h800);
    wr(5'h1c, 32'hffffffff);
    rd(5'h1c, 32'h0);
    ac(32'h1000, 4'ha, 6'h28);
    wr(`OFS_CTRL, 32'h1);
    ac(32'h1000, 4'h2, 6'h30);
    chk({31'h0, irq}, 32'h0);
    wr(`OFS_CTRL, 32'hb);
    ac(32'h1000, 4'h2, 6'h28);
    ac(32'h1000, 4'h0, 6'h30);
    chk({31'h0, irq}, 32'h1);
    wr(`OFS_CTRL, 32'h0);
    wr(`OFS_SELECT, 32'h0);
    wr(`OFS_BASE, 32'h1000);
    wr(`OFS_ATTR, 32'h03000017);
    wr(`OFS_CTRL, 32'h1);
    for (int p = 0; p < 8; p++) begin
      wr(`OFS_ATTR, {5'h0, p[2:0], 24'h000017});
      for (int k = 0; k < 4; k++)
        ac(32'h1040, {k[0], 1'b0, k[1], 1'b0}, ok_tab[p*4+k] ? 6'h20 : 6'h30);
    end
    wr(`OFS_ATTR, 32'h13000017);
    ac(32'h1040, 4'h6, 6'h30);
    wr(`OFS_ATTR, 32'h03000017);
    ac(32'h1040, 4'h6, 6'h20);
    rd(`OFS_ATTR, 32'h03000017);
    wr(`OFS_REGION_ON, 32'h0);
    ac(32'h1040, 4'h0, 6'h30);
    rd(`OFS_BASE, 32'h1000);
    wr(`OFS_REGION_ON, 32'h1);
    ac(32'h1040, 4'h0, 6'h20);
    wr(`OFS_SELECT, 32'h1);
    wr(`OFS_BASE, 32'h1000);
    wr(`OFS_ATTR, 32'h0300010f);
    ac(32'h1000, 4'h0, 6'h20);
    ac(32'h1020, 4'h0, 6'h21);
    wr(`OFS_ATTR, 32'h0300ff0d);
    ac(32'h1000, 4'h0, 6'h21);
    wr(`OFS_SELECT, 32'h2);
    wr(`OFS_BASE, 32'h3000);
    wr(`OFS_ATTR, 32'h03000009);
    ac(32'h301f, 4'h0, 6'h22);
    ac(32'h3020, 4'h0, 6'h30);
    wr(`OFS_ATTR, 32'h03000008);
    ac(32'h3000, 4'h0, 6'h30);
    ac(32'h5000, 4'h1, 6'h28);
    wr(`OFS_CTRL, 32'h5);
    ac(32'h5000, 4'h1, 6'h30);
    rd(`OFS_FAULT_ADDR, 32'h5000);
    rd(`OFS_SELECT, 32'h2);
    finish_test();
  end
endmodule
